// File: verilog/bchr_pkg.sv
// package: offsets, field layout, fixed values and carrier types of the bridge header bank
package bchr_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] BCHR_OFF_CLASS = 8'h08;
  localparam logic [7:0] BCHR_OFF_MISC = 8'h0C;
  localparam logic [7:0] BCHR_OFF_BUS = 8'h18;
  localparam logic [7:0] BCHR_OFF_IO = 8'h1C;
  localparam logic [7:0] BCHR_OFF_IOUP = 8'h30;

  // ----------------------------------------
  // fixed field values
  // ----------------------------------------
  localparam logic [7:0] BCHR_PROG_IF = 8'h00;
  localparam logic [7:0] BCHR_SUB_CLASS = 8'h04;
  localparam logic [7:0] BCHR_BASE_CLASS = 8'h06;
  localparam logic [7:0] BCHR_HDR_TYPE = 8'h01;
  localparam logic [3:0] BCHR_IO32_CODE = 4'h1;
  localparam logic [7:0] BCHR_ZERO8 = 8'h00;
  localparam logic [3:0] BCHR_ZERO4 = 4'h0;
  localparam logic [11:0] BCHR_IO_LO_BASE = 12'h000;
  localparam logic [11:0] BCHR_IO_LO_LIMIT = 12'hFFF;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BCHR_B0 = 0;
  localparam int BCHR_B1 = 8;
  localparam int BCHR_B2 = 16;
  localparam int BCHR_B3 = 24;
  localparam int BCHR_IOB_POS = 4;
  localparam int BCHR_IOL_POS = 12;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] BCHR_RST8 = 8'h00;
  localparam logic [3:0] BCHR_RST4 = 4'h0;
  localparam logic [15:0] BCHR_RST16 = 16'h0000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bchr_req_t;

  typedef struct packed {
    logic [7:0] cache_line;
    logic [7:0] pri_lat;
    logic [7:0] pri_bus;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;
    logic [7:0] sec_lat;
    logic [31:0] io_base;
    logic [31:0] io_limit;
  } bchr_cfg_t;

endpackage

// File: verilog/bchr_lat_timer.sv
// master latency timer: loads on frame start, counts down per clock
`timescale 1ns/1ps
module bchr_lat_timer
  import bchr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic frame_start,
  input wire logic in_txn,
  input wire logic [7:0] lat_value,
  output logic expired
);

  logic [7:0] cnt_ff;
  logic run_ff;
  logic [7:0] nxt_cnt;
  logic nxt_run;

  assign nxt_run = frame_start | (run_ff & in_txn);
  assign nxt_cnt = frame_start ? lat_value :
                   ((run_ff && cnt_ff != BCHR_ZERO8) ? cnt_ff - 8'h01 : cnt_ff);
  // zero setting counts as already expired
  assign expired = run_ff & (cnt_ff == BCHR_ZERO8);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= BCHR_RST8;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end

endmodule

// File: verilog/bchr_regs.sv
// bridge configuration header bank: class, timers, bus numbers, i/o window
// --------------------------------------------------------------------------
// Overview of operation
// - programming interface byte reads zero, not writable
// - sub-class byte reads fixed bridge-to-bridge value
// - base class byte reads fixed bridge device class value
// - cache line size bounds write-invalidate ends and read prefetch size
// - primary latency byte loads timer when primary frame asserts
// - header type byte reads fixed bridge layout value
// - primary bus number byte, writable, resets zero
// - secondary bus number byte, writable, resets zero
// - subordinate bus number byte, writable, resets zero
// - secondary latency byte counts clocks from secondary frame assertion
// - zero secondary timer plus lost grant ends after first data, not mwi
// - low nibbles of i/o base and limit read 32-bit code
// - base nibble gives window bottom bits 15:12, low bits zero
// - limit nibble gives window top bits 15:12, low bits all ones
// - i/o window decides whether an i/o transaction is forwarded
// - window bits 31:16 come from separate upper registers
// --------------------------------------------------------------------------
`timescale 1ns/1ps
module bchr_regs
  import bchr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pri_frame_start,
  input wire logic pri_in_txn,
  output logic pri_lat_expired,
  input wire logic sec_frame_start,
  input wire logic sec_in_txn,
  input wire logic sec_gnt_n,
  input wire logic sec_data_done,
  input wire logic sec_is_mwi,
  output logic sec_stop_req,
  input wire logic [31:0] io_addr,
  output logic io_in_window,
  input wire logic [5:0] mem_burst_dw,
  output logic mwi_line_end,
  output logic [7:0] prefetch_dw,
  output bchr_cfg_t cfg
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] cache_line_ff;
  logic [7:0] pri_lat_ff;
  logic [7:0] pri_bus_ff;
  logic [7:0] sec_bus_ff;
  logic [7:0] sub_bus_ff;
  logic [7:0] sec_lat_ff;
  logic [3:0] io_base_ff;
  logic [3:0] io_limit_ff;
  logic [15:0] io_base_up_ff;
  logic [15:0] io_limit_up_ff;
  logic [31:0] rdata_ff;

  // ----------------------------------------
  // request carrier
  // ----------------------------------------
  bchr_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ----------------------------------------
  // address hits
  // ----------------------------------------
  function automatic logic hit(input bchr_req_t r, input logic [7:0] off);
    hit = (r.addr == off);
  endfunction

  wire hit_class = hit(req, BCHR_OFF_CLASS);
  wire hit_misc = hit(req, BCHR_OFF_MISC);
  wire hit_bus = hit(req, BCHR_OFF_BUS);
  wire hit_io = hit(req, BCHR_OFF_IO);
  wire hit_ioup = hit(req, BCHR_OFF_IOUP);

  // ----------------------------------------
  // write enables
  // ----------------------------------------
  // no enable for the class word: writes there are dropped
  wire wr_misc = req.wr & hit_misc;
  wire wr_bus = req.wr & hit_bus;
  wire wr_io = req.wr & hit_io;
  wire wr_ioup = req.wr & hit_ioup;

  // ----------------------------------------
  // write data fields
  // ----------------------------------------
  wire [7:0] wd_cache_line = req.wdata[BCHR_B0+:8];
  wire [7:0] wd_pri_lat = req.wdata[BCHR_B1+:8];
  wire [7:0] wd_pri_bus = req.wdata[BCHR_B0+:8];
  wire [7:0] wd_sec_bus = req.wdata[BCHR_B1+:8];
  wire [7:0] wd_sub_bus = req.wdata[BCHR_B2+:8];
  wire [7:0] wd_sec_lat = req.wdata[BCHR_B3+:8];
  wire [3:0] wd_io_base = req.wdata[BCHR_IOB_POS+:4];
  wire [3:0] wd_io_limit = req.wdata[BCHR_IOL_POS+:4];
  wire [15:0] wd_io_base_up = req.wdata[BCHR_B0+:16];
  wire [15:0] wd_io_limit_up = req.wdata[BCHR_B2+:16];

  // ----------------------------------------
  // next values
  // ----------------------------------------
  // only writable fields are stored; fixed bytes have no flops
  wire [7:0] nxt_cache_line = wr_misc ? wd_cache_line : cache_line_ff;
  wire [7:0] nxt_pri_lat = wr_misc ? wd_pri_lat : pri_lat_ff;
  wire [7:0] nxt_pri_bus = wr_bus ? wd_pri_bus : pri_bus_ff;
  wire [7:0] nxt_sec_bus = wr_bus ? wd_sec_bus : sec_bus_ff;
  wire [7:0] nxt_sub_bus = wr_bus ? wd_sub_bus : sub_bus_ff;
  wire [7:0] nxt_sec_lat = wr_bus ? wd_sec_lat : sec_lat_ff;
  wire [3:0] nxt_io_base = wr_io ? wd_io_base : io_base_ff;
  wire [3:0] nxt_io_limit = wr_io ? wd_io_limit : io_limit_ff;
  wire [15:0] nxt_io_base_up = wr_ioup ? wd_io_base_up : io_base_up_ff;
  wire [15:0] nxt_io_limit_up = wr_ioup ? wd_io_limit_up : io_limit_up_ff;

  // ----------------------------------------
  // misc word flops
  // ----------------------------------------
  // stored as written, legality is software's duty
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cache_line_ff <= BCHR_RST8;
    end else begin
      cache_line_ff <= nxt_cache_line;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pri_lat_ff <= BCHR_RST8;
    end else begin
      pri_lat_ff <= nxt_pri_lat;
    end
  end

  // ----------------------------------------
  // bus word flops
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pri_bus_ff <= BCHR_RST8;
    end else begin
      pri_bus_ff <= nxt_pri_bus;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sec_bus_ff <= BCHR_RST8;
    end else begin
      sec_bus_ff <= nxt_sec_bus;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sub_bus_ff <= BCHR_RST8;
    end else begin
      sub_bus_ff <= nxt_sub_bus;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sec_lat_ff <= BCHR_RST8;
    end else begin
      sec_lat_ff <= nxt_sec_lat;
    end
  end

  // ----------------------------------------
  // io word flops
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_base_ff <= BCHR_RST4;
    end else begin
      io_base_ff <= nxt_io_base;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_limit_ff <= BCHR_RST4;
    end else begin
      io_limit_ff <= nxt_io_limit;
    end
  end

  // ----------------------------------------
  // io upper flops
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_base_up_ff <= BCHR_RST16;
    end else begin
      io_base_up_ff <= nxt_io_base_up;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_limit_up_ff <= BCHR_RST16;
    end else begin
      io_limit_up_ff <= nxt_io_limit_up;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // fixed bytes come from constants, not flops
  wire [31:0] rd_class = {BCHR_BASE_CLASS, BCHR_SUB_CLASS,
                          BCHR_PROG_IF, 8'h00};
  wire [31:0] rd_misc = {BCHR_ZERO8, BCHR_HDR_TYPE,
                         pri_lat_ff, cache_line_ff};
  wire [31:0] rd_bus = {sec_lat_ff, sub_bus_ff,
                        sec_bus_ff, pri_bus_ff};
  wire [31:0] rd_io = {BCHR_ZERO8,
                       BCHR_ZERO8,
                       io_limit_ff,
                       BCHR_IO32_CODE,
                       io_base_ff,
                       BCHR_IO32_CODE};
  wire [31:0] rd_ioup = {io_limit_up_ff,
                         io_base_up_ff};

  // unmapped offsets read zero; fixed bytes ignore writes
  wire [31:0] rd_sel = hit_class ? rd_class :
                       hit_misc ? rd_misc :
                       hit_bus ? rd_bus :
                       hit_io ? rd_io :
                       hit_ioup ? rd_ioup : 32'h00000000;

  // ----------------------------------------
  // read data flop
  // ----------------------------------------
  // data stand one cycle, zero otherwise
  wire [31:0] nxt_rdata = req.rd ? rd_sel :
                          32'h00000000;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------
  // i/o window decode
  // ----------------------------------------
  wire [31:0] io_bottom = {io_base_up_ff, io_base_ff,
                           BCHR_IO_LO_BASE};
  wire [31:0] io_top = {io_limit_up_ff, io_limit_ff,
                        BCHR_IO_LO_LIMIT};
  wire above_bottom = (io_addr >= io_bottom);
  wire below_top = (io_addr <= io_top);
  assign io_in_window = above_bottom && below_top;

  // ----------------------------------------
  // cache line use
  // ----------------------------------------
  // burst dword index wraps on line boundary; zero line size never ends early
  wire [7:0] burst_ext = {2'b00, mem_burst_dw};
  wire [7:0] line_mask = cache_line_ff - 8'h01;
  wire line_size_set = (cache_line_ff != BCHR_ZERO8);
  wire at_line_end = ((burst_ext & line_mask) == line_mask);
  assign mwi_line_end = line_size_set && at_line_end;
  assign prefetch_dw = cache_line_ff;

  // ----------------------------------------
  // latency timers
  // ----------------------------------------
  // lane 0 primary, lane 1 secondary
  logic [1:0] tmr_start;
  logic [1:0] tmr_busy;
  logic [1:0][7:0] tmr_value;
  logic [1:0] tmr_expired;
  logic sec_lat_expired;

  assign tmr_start = {sec_frame_start, pri_frame_start};
  assign tmr_busy = {sec_in_txn, pri_in_txn};
  assign tmr_value[0] = pri_lat_ff;
  assign tmr_value[1] = sec_lat_ff;
  assign pri_lat_expired = tmr_expired[0];
  assign sec_lat_expired = tmr_expired[1];

  generate
    for (genvar g = 0; g < 2; g++) begin : g_timer
      bchr_lat_timer u_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .frame_start(tmr_start[g]),
        .in_txn(tmr_busy[g]),
        .lat_value(tmr_value[g]),
        .expired(tmr_expired[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // stop decision
  // ----------------------------------------
  // stop once grant is gone, timer has run out and first data is done, except for mwi
  wire sec_grant_lost = sec_in_txn & sec_gnt_n;
  wire sec_timer_out = sec_grant_lost & sec_lat_expired;
  wire sec_may_stop = ~sec_is_mwi & sec_data_done;
  assign sec_stop_req = sec_timer_out & sec_may_stop;

  // ----------------------------------------
  // configuration view
  // ----------------------------------------
  assign cfg = '{cache_line: cache_line_ff,
                 pri_lat: pri_lat_ff,
                 pri_bus: pri_bus_ff,
                 sec_bus: sec_bus_ff,
                 sub_bus: sub_bus_ff,
                 sec_lat: sec_lat_ff,
                 io_base: io_bottom,
                 io_limit: io_top};

endmodule

// File: verification/bchr_regs_checker.sv
// checker: port-level properties of the bridge header bank
`timescale 1ns/1ps
module bchr_regs_checker
  import bchr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic pri_frame_start,
  input wire logic pri_lat_expired,
  input wire logic sec_frame_start,
  input wire logic sec_in_txn,
  input wire logic sec_gnt_n,
  input wire logic sec_data_done,
  input wire logic sec_is_mwi,
  input wire logic sec_stop_req,
  input wire logic [31:0] io_addr,
  input wire logic io_in_window,
  input wire logic [7:0] prefetch_dw,
  input wire bchr_cfg_t cfg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_CLASS_RD: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata == 32'h06040000)
    else $error("class code word read wrong");
  AST_HDR_RD: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata[31:16] == 16'h0001)
    else $error("header type byte read wrong");
  AST_IO_CODE_RD: assert property (reg_rd && reg_addr == 8'h1C |=>
    reg_rdata[3:0] == 4'h1 && reg_rdata[11:8] == 4'h1) else $error("io addressing code wrong");
  AST_BUS_WR: assert property (reg_wr && reg_addr == 8'h18 |=>
    {cfg.sec_lat, cfg.sub_bus, cfg.sec_bus, cfg.pri_bus} == $past(reg_wdata))
    else $error("bus number word not stored");
  AST_IO_WR: assert property (reg_wr && reg_addr == 8'h1C |=> cfg.io_base[15:0] ==
    {$past(reg_wdata[7:4]), 12'h000} && cfg.io_limit[15:0] == {$past(reg_wdata[15:12]), 12'hFFF})
    else $error("io window edges wrong");
  AST_IO_HIT: assert property (io_in_window == (io_addr >= cfg.io_base && io_addr <= cfg.io_limit))
    else $error("io window decision wrong");
  AST_PREFETCH: assert property (prefetch_dw == cfg.cache_line)
    else $error("prefetch size differs from cache line size");
  AST_PRI_HOLD: assert property (pri_frame_start && cfg.pri_lat == 8'h03 |=> !pri_lat_expired [*3])
    else $error("primary timer expired early");
  AST_SEC_STOP: assert property (sec_frame_start && cfg.sec_lat == 8'h00 ##1
    (sec_in_txn && sec_gnt_n && sec_data_done && !sec_is_mwi) |-> sec_stop_req)
    else $error("no stop after first data with zero timer");
  AST_MWI_GO: assert property (sec_is_mwi || !sec_gnt_n |-> !sec_stop_req)
    else $error("stop raised for mwi or while granted");
endmodule

bind bchr_regs bchr_regs_checker chk (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pri_frame_start, .pri_lat_expired, .sec_frame_start, .sec_in_txn, .sec_gnt_n,
  .sec_data_done, .sec_is_mwi, .sec_stop_req, .io_addr, .io_in_window, .prefetch_dw, .cfg);

// File: verification/bchr_regs_bench.sv
// testbench: register map, timers and io window of the bridge header bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module bchr_regs_bench
  import bchr_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, io_addr = 32'h0, reg_rdata;
  logic pri_frame_start = 1'b0, pri_in_txn = 1'b0, sec_frame_start = 1'b0, sec_in_txn = 1'b0;
  logic sec_gnt_n = 1'b0, sec_data_done = 1'b0, sec_is_mwi = 1'b0;
  logic [5:0] mem_burst_dw = 6'h00;
  logic pri_lat_expired, sec_stop_req, io_in_window, mwi_line_end;
  logic [7:0] prefetch_dw;
  bchr_cfg_t cfg;
  int n_fail = 0, n_compared = 0;
  logic [7:0] cls [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
  logic [31:0] ioa [5] = '{32'h00003000, 32'h00012FFF, 32'h00013000, 32'h00025FFF, 32'h00026000};
  logic ioe [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  always #12.5 ref_clk = ~ref_clk;
  bchr_regs uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pri_frame_start(pri_frame_start),
    .pri_in_txn(pri_in_txn), .pri_lat_expired(pri_lat_expired),
    .sec_frame_start(sec_frame_start), .sec_in_txn(sec_in_txn), .sec_gnt_n(sec_gnt_n),
    .sec_data_done(sec_data_done), .sec_is_mwi(sec_is_mwi), .sec_stop_req(sec_stop_req),
    .io_addr(io_addr), .io_in_window(io_in_window), .mem_burst_dw(mem_burst_dw),
    .mwi_line_end(mwi_line_end), .prefetch_dw(prefetch_dw), .cfg(cfg));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk); reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic t_fixed();
    rd(8'h08, 32'h06040000);
    rd(8'h0C, 32'h00010000);
    rd(8'h18, 32'h00000000);
    rd(8'h1C, 32'h00000101);
    wr(8'h08, 32'hFFFFFFFF); wr(8'h0C, 32'hFFFFFFFF); wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h08, 32'h06040000);
    rd(8'h0C, 32'h0001FFFF);
    rd(8'h1C, 32'h0000F1F1);
    rd(8'h40, 32'h00000000);
  endtask
  task automatic t_bus();
    wr(8'h18, 32'h40302010);
    rd(8'h18, 32'h40302010);
    `CHK(cfg.sub_bus, 8'h30)
    `CHK(cfg.sec_lat, 8'h40)
  endtask
  task automatic t_cache();
    foreach (cls[i]) begin
      wr(8'h0C, {24'h0, cls[i]});
      rd(8'h0C, {24'h000100, cls[i]});
      `CHK(prefetch_dw, cls[i])
    end
    wr(8'h0C, 32'h00000004);
    for (int k = 2; k < 8; k++) begin
      @(posedge ref_clk); mem_burst_dw <= 6'(k);
      #1 `CHK(mwi_line_end, k[1:0] == 2'b11)
    end
  endtask
  task automatic t_io();
    wr(8'h1C, 32'h00005030);
    rd(8'h1C, 32'h00005131);
    `CHK(cfg.io_limit, 32'h00005FFF)
    wr(8'h30, 32'h00020001);
    #1 `CHK(cfg.io_base, 32'h00013000)
    foreach (ioa[i]) begin
      @(posedge ref_clk); io_addr <= ioa[i];
      #1 `CHK(io_in_window, ioe[i])
    end
  endtask
  task automatic t_timers();
    wr(8'h0C, 32'h00000300);
    @(posedge ref_clk); pri_frame_start <= 1'b1; pri_in_txn <= 1'b1;
    @(posedge ref_clk); pri_frame_start <= 1'b0;
    repeat (3) begin #1 `CHK(pri_lat_expired, 1'b0) @(posedge ref_clk); end
    #1 `CHK(pri_lat_expired, 1'b1)
    @(posedge ref_clk); pri_in_txn <= 1'b0;
    wr(8'h18, 32'h00302010);
    @(posedge ref_clk); sec_frame_start <= 1'b1; sec_in_txn <= 1'b1; sec_gnt_n <= 1'b1;
    sec_data_done <= 1'b1;
    @(posedge ref_clk); sec_frame_start <= 1'b0;
    #1 `CHK(sec_stop_req, 1'b1)
    @(posedge ref_clk); sec_is_mwi <= 1'b1;
    #1 `CHK(sec_stop_req, 1'b0)
    @(posedge ref_clk); sec_is_mwi <= 1'b0; sec_gnt_n <= 1'b0;
    #1 `CHK(sec_stop_req, 1'b0)
    @(posedge ref_clk); sec_in_txn <= 1'b0; sec_data_done <= 1'b0;
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_fixed();
    t_bus();
    t_cache();
    t_io();
    t_timers();
    test_done();
  end
endmodule
